// >>> safety_sup_pkg.sv
package safety_sup_pkg;
  // ==========================================
  // Clock and times.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FB_WIN_MS = 500;
  localparam logic [31:0] FB_WIN_CYC = 32'(FB_WIN_MS * CYC_PER_MS);
  localparam int unsigned SIMUL_MS = 500;
  localparam logic [31:0] SIMUL_CYC = 32'(SIMUL_MS * CYC_PER_MS);
  localparam int unsigned LINK_EXT_MS = 20;
  localparam logic [31:0] LINK_EXT_CYC = 32'(LINK_EXT_MS * CYC_PER_MS);
  localparam int unsigned DLY_EXT_MS = 40;
  localparam logic [31:0] DLY_EXT_CYC = 32'(DLY_EXT_MS * CYC_PER_MS);
  localparam int unsigned SYNC_MS = 40;
  localparam logic [31:0] SYNC_CYC = 32'(SYNC_MS * CYC_PER_MS);
  // ==========================================
  // Field pairs, contour and indications.
  localparam logic [15:0] CONTOUR_TOL_MM = 16'h00C8;
  localparam int unsigned NUM_PAIRS = 10;
  localparam int unsigned TAB_BITS = NUM_PAIRS * NUM_PAIRS;
  localparam logic [3:0] PAIR_RESET = 4'h0;
  localparam logic [4:0] PAT_RESET = 5'h00;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam int unsigned IND_NUM = 4;
  localparam int unsigned MAP_W = 3;
endpackage : safety_sup_pkg

// >>> pair_sel_if.sv
`timescale 1ns/100ps
// Control pattern in, monitored field pair and changeover state out.
interface pair_sel_if;
  logic [4:0] pattern;
  logic [3:0] pair;
  logic pair_valid;
  logic changing;
  logic sel_fault;
  logic settled;
  modport sel (input pattern, output pair, output pair_valid, output changing,
    output sel_fault, output settled);
  modport user (output pattern, input pair, input pair_valid, input changing,
    input sel_fault, input settled);
endinterface : pair_sel_if

// >>> field_pair_select.sv
`timescale 1ns/100ps
module field_pair_select (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [31:0] changeover_cyc,
  input wire logic order_check_en,
  input wire logic [safety_sup_pkg::TAB_BITS-1:0] allowed_in,
  input wire logic [9:0] deactivated,
  input wire logic cfg_load,
  pair_sel_if.sel sel
);
  typedef enum {ST_STABLE, ST_SWITCH} co_state_e;
  co_state_e state;
  logic [31:0] timer;
  logic [4:0] last_pat;
  logic [safety_sup_pkg::TAB_BITS-1:0] allow_tab;
  logic [4:0] hot_hit;
  logic [4:0] low_hit;
  logic [3:0] idx_term [10];
  logic [3:0] dec_idx;
  logic dec_valid;
  logic [6:0] tab_idx;
  logic permitted;
  logic expire;

  // ==========================================
  // Pattern decode, one term per field pair.
  genvar k;
  for (k = 0; k < 5; k++) begin : g_dec
    assign hot_hit[k] = (sel.pattern == 5'(1 << k));
    assign low_hit[k] = (sel.pattern == ~5'(1 << k));
    assign idx_term[k] = hot_hit[k] ? 4'(k) : 4'h0;
    assign idx_term[k + 5] = low_hit[k] ? 4'(9 - k) : 4'h0;
  end
  assign dec_valid = |{hot_hit, low_hit};
  assign dec_idx = idx_term[0] | idx_term[1] | idx_term[2] | idx_term[3]
    | idx_term[4] | idx_term[5] | idx_term[6] | idx_term[7] | idx_term[8]
    | idx_term[9];

  // A first adoption after reset has no previous pair to check against.
  assign tab_idx = {3'h0, sel.pair} * 7'h0A + {3'h0, dec_idx};
  assign permitted = !order_check_en
    || ((!sel.pair_valid || allow_tab[tab_idx]) && !deactivated[dec_idx]);
  assign expire = (state == ST_SWITCH) && (timer == safety_sup_pkg::CNT_ZERO);
  assign sel.changing = (state == ST_SWITCH);

  // The table only changes on a configuration load, never by itself.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      allow_tab <= '0;
    end else if (cfg_load) begin
      allow_tab <= allowed_in;
    end
  end

  // Fixed changeover moment: the old pair stays until the timer ends.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_STABLE;
      timer <= safety_sup_pkg::CNT_ZERO;
      last_pat <= safety_sup_pkg::PAT_RESET;
      sel.pair <= safety_sup_pkg::PAIR_RESET;
      sel.pair_valid <= 1'b0;
      sel.sel_fault <= 1'b0;
      sel.settled <= 1'b0;
    end else begin
      sel.settled <= 1'b0;
      last_pat <= sel.pattern;
      unique case (state)
        ST_STABLE: begin
          if (sel.pattern != last_pat) begin
            state <= ST_SWITCH;
            timer <= changeover_cyc;
          end
        end
        ST_SWITCH: begin
          if (!expire) begin
            timer <= timer - 32'h0000_0001;
          end else begin
            state <= ST_STABLE;
            if (dec_valid && permitted) begin
              sel.pair <= dec_idx;
              sel.pair_valid <= 1'b1;
              sel.sel_fault <= 1'b0;
              sel.settled <= 1'b1;
            end else begin
              sel.sel_fault <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  a_old_pair_held: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_SWITCH && !expire) |=> $stable(sel.pair))
    else $error("Monitored pair changed before changeover time ended.");
  a_bad_code_fault: assert property (@(posedge clk) disable iff (!arst_n)
    (expire && !dec_valid) |=> sel.sel_fault && !sel.settled)
    else $error("Invalid pattern at changeover end raised no fault.");
  a_order_refused: assert property (@(posedge clk) disable iff (!arst_n)
    (expire && dec_valid && order_check_en && sel.pair_valid
      && !allow_tab[tab_idx]) |=> sel.sel_fault && $stable(sel.pair))
    else $error("Unlisted changeover was accepted.");
  a_deact_refused: assert property (@(posedge clk) disable iff (!arst_n)
    (expire && dec_valid && order_check_en && deactivated[dec_idx])
      |=> sel.sel_fault)
    else $error("Changeover into deactivated pair was accepted.");
  a_one_low_code: assert property (@(posedge clk) disable iff (!arst_n)
    (sel.pattern == 5'h0F) |-> dec_valid && dec_idx == 4'h5)
    else $error("One-low pattern did not select the sixth pair.");
endmodule : field_pair_select

// >>> safety_output_supervisor.sv
`timescale 1ns/100ps
module safety_output_supervisor #(
  parameter logic [31:0] FB_CYC = safety_sup_pkg::FB_WIN_CYC,
  parameter logic [31:0] SIMUL_CYC = safety_sup_pkg::SIMUL_CYC,
  parameter logic [31:0] LINK_EXT_CYC = safety_sup_pkg::LINK_EXT_CYC,
  parameter logic [31:0] DLY_EXT_CYC = safety_sup_pkg::DLY_EXT_CYC,
  parameter logic [31:0] SYNC_CYC = safety_sup_pkg::SYNC_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] pair_select_group_a,
  input wire logic [4:0] pair_select_group_b,
  input wire logic two_functions,
  input wire logic order_check_en,
  input wire logic [31:0] changeover_cyc,
  input wire logic [safety_sup_pkg::TAB_BITS-1:0] allowed_a,
  input wire logic [safety_sup_pkg::TAB_BITS-1:0] allowed_b,
  input wire logic [9:0] deactivated_a,
  input wire logic [9:0] deactivated_b,
  input wire logic [9:0] standby_a,
  input wire logic [9:0] standby_b,
  input wire logic cfg_load,
  input wire logic [1:0] field_free,
  input wire logic [1:0] warn_free,
  input wire logic contour_check_en,
  input wire logic [15:0] contour_dev_mm,
  input wire logic delay_en,
  input wire logic [31:0] delay_cyc,
  input wire logic fb_check_en,
  input wire logic [1:0] contactor_feedback_in,
  input wire logic [1:0] link_mode,
  input wire logic [1:0] link_ch,
  input wire logic fault_reset,
  input wire logic [11:0] ind_map,
  output logic [1:0] safe_out_pair_a,
  output logic [1:0] safe_out_pair_b,
  output logic [3:0] monitored_pair_a,
  output logic [3:0] monitored_pair_b,
  output logic [1:0] monitoring_active,
  output logic fault_interlock,
  output logic link_fault,
  output logic [3:0] indication
);
  // ==========================================
  // Declarations.
  pair_sel_if ifc [2] ();
  logic [1:0][4:0] pat_w;
  logic [1:0][safety_sup_pkg::TAB_BITS-1:0] allowed_w;
  logic [1:0][9:0] deact_w;
  logic [1:0][9:0] standby_w;
  logic [1:0] standby_hit;
  logic [1:0] pair_ok;
  logic [1:0] sel_bad;
  logic [1:0] changing;
  logic [1:0] imm_off;
  logic [1:0] slow_off;
  logic [1:0] hold_ok;
  logic [31:0] off_cnt [2];
  logic [31:0] sync_cnt [2];
  logic [31:0] limit [2];
  logic contour_trip;
  logic link_on;
  logic link_ok;
  logic link_ok_eff;
  logic [31:0] sim_cnt;
  logic [1:0] out_on;
  logic [1:0] tgt;
  logic [1:0] can_on;
  logic [1:0] fb_wait;
  logic [1:0] fb_exp;
  logic [1:0] fb_err;
  logic [31:0] fb_cnt [2];
  logic [31:0] dly_cnt;
  logic dly_run;
  logic delayed_mode;
  logic a_fell;
  logic out_a_q;
  logic [7:0] events;

  // ==========================================
  // Field pair selection, one selector per protective function.
  assign pat_w = {pair_select_group_b, pair_select_group_a};
  assign allowed_w = {allowed_b, allowed_a};
  assign deact_w = {deactivated_b, deactivated_a};
  assign standby_w = {standby_b, standby_a};

  genvar f;
  for (f = 0; f < 2; f++) begin : g_fn
    assign ifc[f].pattern = pat_w[f];
    assign pair_ok[f] = ifc[f].pair_valid;
    assign sel_bad[f] = ifc[f].sel_fault;
    assign changing[f] = ifc[f].changing;

    field_pair_select u_sel (
      .clk(clk),
      .arst_n(arst_n),
      .changeover_cyc(changeover_cyc),
      .order_check_en(order_check_en),
      .allowed_in(allowed_w[f]),
      .deactivated(deact_w[f]),
      .cfg_load(cfg_load),
      .sel(ifc[f])
    );

    // A standby pair is not watched at all, so it cannot permit outputs.
    assign standby_hit[f] = pair_ok[f] && standby_w[f][ifc[f].pair];
    assign monitoring_active[f] = pair_ok[f] && !standby_hit[f];

    // Causes that must act at once versus those the response time covers.
    assign imm_off[f] = fault_interlock || sel_bad[f] || standby_hit[f]
      || !pair_ok[f];
    assign slow_off[f] = !field_free[f] || contour_trip || !link_ok_eff;

    // Linkage lengthens the response; a fresh pair adds the sync time.
    assign limit[f] = (link_on ? LINK_EXT_CYC : safety_sup_pkg::CNT_ZERO)
      + ((sync_cnt[f] != safety_sup_pkg::CNT_ZERO) ? SYNC_CYC
      : safety_sup_pkg::CNT_ZERO);

    // Sync window opens when a new pair is adopted.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync_cnt[f] <= safety_sup_pkg::CNT_ZERO;
      end else if (ifc[f].settled) begin
        sync_cnt[f] <= SYNC_CYC;
      end else if (sync_cnt[f] != safety_sup_pkg::CNT_ZERO) begin
        sync_cnt[f] <= sync_cnt[f] - 32'h0000_0001;
      end
    end

    // The trip filter drops the permission once a cause outlasts its limit.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        hold_ok[f] <= 1'b0;
        off_cnt[f] <= safety_sup_pkg::CNT_ZERO;
      end else if (imm_off[f] || !slow_off[f]) begin
        hold_ok[f] <= !imm_off[f];
        off_cnt[f] <= safety_sup_pkg::CNT_ZERO;
      end else if (off_cnt[f] >= limit[f]) begin
        hold_ok[f] <= 1'b0;
      end else begin
        off_cnt[f] <= off_cnt[f] + 32'h0000_0001;
      end
    end
  end

  assign monitored_pair_a = ifc[0].pair;
  assign monitored_pair_b = ifc[1].pair;

  // Tolerance is compared here; the deviation is measured upstream.
  assign contour_trip = contour_check_en
    && (contour_dev_mm > safety_sup_pkg::CONTOUR_TOL_MM);

  // ==========================================
  // Two-channel linkage to an upstream chain.
  // Contact and electronic chains share one checker: closed and on are both
  // reported high on link_ch, and either channel low forces the outputs off.
  assign link_on = (link_mode != 2'h0);
  assign link_ok_eff = !link_on || link_ok;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_ok <= 1'b0;
      link_fault <= 1'b0;
      sim_cnt <= safety_sup_pkg::CNT_ZERO;
    end else if (!link_on || link_ch == 2'h0) begin
      link_ok <= 1'b0;
      link_fault <= 1'b0;
      sim_cnt <= safety_sup_pkg::CNT_ZERO;
    end else if (link_ch == 2'h3) begin
      link_ok <= !link_fault && (sim_cnt <= SIMUL_CYC);
    end else begin
      link_ok <= 1'b0;
      if (sim_cnt > SIMUL_CYC) begin
        link_fault <= 1'b1;
      end else begin
        sim_cnt <= sim_cnt + 32'h0000_0001;
      end
    end
  end

  // ==========================================
  // Output targets and the internal delayed switch-off.
  assign delayed_mode = !two_functions && delay_en;
  assign dly_run = (dly_cnt != safety_sup_pkg::CNT_ZERO);
  assign a_fell = out_a_q && !out_on[0];
  assign tgt[0] = hold_ok[0];
  assign tgt[1] = two_functions ? hold_ok[1]
    : (delayed_mode ? (out_on[0] || out_a_q || dly_run) : out_on[0]);

  // Pair A may not restart while the delayed pair is still counting.
  assign can_on[0] = (!fb_check_en || contactor_feedback_in[0]) && !dly_run;
  assign can_on[1] = (!fb_check_en || contactor_feedback_in[1]);

  // Delay counter; linkage stretches it by DLY_EXT_CYC, on top of the lag pair A already gets.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_cnt <= safety_sup_pkg::CNT_ZERO;
      out_a_q <= 1'b0;
    end else begin
      out_a_q <= out_on[0];
      if (delayed_mode && a_fell) begin
        dly_cnt <= delay_cyc
          + (link_on ? DLY_EXT_CYC : safety_sup_pkg::CNT_ZERO);
      end else if (dly_run) begin
        dly_cnt <= dly_cnt - 32'h0000_0001;
      end
    end
  end

  // ==========================================
  // Output stages with dynamic contactor checking, one per pair.
  // Expected feedback is closed while off and open while on.
  genvar p;
  for (p = 0; p < 2; p++) begin : g_out
    assign fb_err[p] = fb_wait[p] && (fb_cnt[p] >= FB_CYC)
      && (contactor_feedback_in[p] != fb_exp[p]);

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        out_on[p] <= 1'b0;
      end else if (fault_interlock || !tgt[p]) begin
        out_on[p] <= 1'b0;
      end else if (!out_on[p] && can_on[p]) begin
        out_on[p] <= 1'b1;
      end
    end

    // Each output edge restarts the watch for the feedback to follow.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        fb_wait[p] <= 1'b0;
        fb_exp[p] <= 1'b1;
        fb_cnt[p] <= safety_sup_pkg::CNT_ZERO;
      end else if (out_on[p] != !fb_exp[p]) begin
        fb_wait[p] <= fb_check_en;
        fb_exp[p] <= !out_on[p];
        fb_cnt[p] <= safety_sup_pkg::CNT_ZERO;
      end else if (fb_wait[p]) begin
        if (contactor_feedback_in[p] == fb_exp[p]) begin
          fb_wait[p] <= 1'b0;
        end else if (fb_cnt[p] < FB_CYC) begin
          fb_cnt[p] <= fb_cnt[p] + 32'h0000_0001;
        end else begin
          fb_wait[p] <= 1'b0;
        end
      end
    end
  end

  assign safe_out_pair_a = {2{out_on[0]}};
  assign safe_out_pair_b = {2{out_on[1]}};

  // A new error wins over a reset request in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_interlock <= 1'b0;
    end else if (|fb_err) begin
      fault_interlock <= 1'b1;
    end else if (fault_reset) begin
      fault_interlock <= 1'b0;
    end
  end

  // ==========================================
  // Indication outputs, each picking one event by its map field.
  assign events = {
    |fb_wait,
    link_fault || contour_trip,
    fault_interlock || (|sel_bad),
    |changing,
    !warn_free[1],
    !warn_free[0],
    !field_free[1],
    !field_free[0]
  };

  genvar i;
  for (i = 0; i < safety_sup_pkg::IND_NUM; i++) begin : g_ind
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        indication[i] <= 1'b0;
      end else begin
        indication[i] <= events[ind_map[i*safety_sup_pkg::MAP_W +: 3]];
      end
    end
  end

  // ==========================================
  // Checks.
  a_standby_off: assert property (@(posedge clk) disable iff (!arst_n)
    standby_hit[0] |=> !hold_ok[0] ##1 !out_on[0])
    else $error("Standby pair left output A on.");
  a_contour_off: assert property (@(posedge clk) disable iff (!arst_n)
    (contour_trip && !link_on && sync_cnt[0] == safety_sup_pkg::CNT_ZERO) [*2]
      |=> !out_on[0])
    else $error("Contour deviation did not switch output A off.");
  a_fb_fault: assert property (@(posedge clk) disable iff (!arst_n)
    (|fb_err) |=> fault_interlock ##1 (out_on == 2'h0))
    else $error("Feedback error did not latch and force outputs off.");
  a_fb_closed: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(out_on[0]) |-> $past(!fb_check_en || contactor_feedback_in[0]))
    else $error("Output A switched on with open feedback.");
  a_restart_block: assert property (@(posedge clk) disable iff (!arst_n)
    dly_run |=> !$rose(out_on[0]))
    else $error("Output A restarted during the delay.");
  a_link_drop: assert property (@(posedge clk) disable iff (!arst_n)
    (link_on && link_ch != 2'h3)
      |=> !link_ok)
    else $error("Upstream off did not clear the linkage permission.");
  a_delay_follow: assert property (@(posedge clk) disable iff (!arst_n)
    (delayed_mode && a_fell && !fault_interlock && delay_cyc > 32'h0000_0002)
      ##1 !fault_interlock |-> out_on[1])
    else $error("Delayed pair B dropped together with pair A.");
  a_link_late: assert property (@(posedge clk) disable iff (!arst_n)
    (link_on && link_ch == 2'h1 && sim_cnt > SIMUL_CYC) |=> link_fault && !link_ok)
    else $error("Late reclose raised no linkage fault.");
endmodule : safety_output_supervisor

// >>> contactor_model.sv
`timescale 1ns/100ps
// ====================
// Contactor pair model
// Downstream contactors seen through their feedback contacts.
module contactor_model #(
  parameter int LAG = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] coil,
  input wire logic [1:0] weld,
  input wire logic [1:0] brk,
  output logic [1:0] fb
);
  logic [2*LAG-1:0] pipe;
  // The shift stands for armature travel, so feedback never follows the coil at once.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[2*LAG-3:0], coil};
    end
  end
  // Closed while released and open while pulled in; weld and break inject faults.
  assign fb = (~pipe[2*LAG-1 -: 2] | weld) & ~brk;
endmodule : contactor_model

// >>> tb_safety_output_supervisor.sv
`timescale 1ns/100ps
module tb_safety_output_supervisor;
  // ====================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] grp_a = 5'h00, grp_b = 5'h00;
  logic two_fn = 1'b1, order_en = 1'b0, cfg_load = 1'b0, ctr_en = 1'b1;
  logic delay_en = 1'b0, fault_rst = 1'b0, intl, lfault;
  logic [safety_sup_pkg::TAB_BITS-1:0] allow_a = '1;
  logic [9:0] deact = 10'h000, stby = 10'h000;
  logic [1:0] field = 2'h3, link_mode = 2'h0, link_ch = 2'h3;
  logic [1:0] weld = 2'h0, brk = 2'h0, fb, out_a, out_b, mon_act;
  logic [15:0] dev = 16'h00C8;
  logic [3:0] pair_a, pair_b, ind;
  logic fb_chk_en = 1'b1;
  logic [31:0] co_cyc = 32'h0000_0003, dly_cyc = 32'h0000_000A;
  logic [safety_sup_pkg::TAB_BITS-1:0] allow_b = '1;
  logic [11:0] ind_map = 12'h560;
  int errors = 0, total_checks = 0, cycles = 0;
  // Short windows keep every timed path within a few dozen cycles.
  safety_output_supervisor #(.FB_CYC(32'h14), .SIMUL_CYC(32'h14), .LINK_EXT_CYC(32'h4),
    .DLY_EXT_CYC(32'h4), .SYNC_CYC(32'h6)) dut_u (
    .clk(clk),
    .arst_n(arst_n),
    .pair_select_group_a(grp_a),
    .pair_select_group_b(grp_b),
    .two_functions(two_fn),
    .order_check_en(order_en),
    .changeover_cyc(co_cyc),
    .allowed_a(allow_a),
    .allowed_b(allow_b),
    .deactivated_a(deact),
    .deactivated_b(deact),
    .standby_a(stby),
    .standby_b(stby),
    .cfg_load(cfg_load),
    .field_free(field),
    .warn_free(field),
    .contour_check_en(ctr_en),
    .contour_dev_mm(dev),
    .delay_en(delay_en),
    .delay_cyc(dly_cyc),
    .fb_check_en(fb_chk_en),
    .contactor_feedback_in(fb),
    .link_mode(link_mode),
    .link_ch(link_ch),
    .fault_reset(fault_rst),
    .ind_map(ind_map),
    .safe_out_pair_a(out_a),
    .safe_out_pair_b(out_b),
    .monitored_pair_a(pair_a),
    .monitored_pair_b(pair_b),
    .monitoring_active(mon_act),
    .fault_interlock(intl),
    .link_fault(lfault),
    .indication(ind)
  );
  contactor_model cont_u (
    .clk(clk),
    .arst_n(arst_n),
    .coil({out_b[0], out_a[0]}),
    .weld(weld),
    .brk(brk),
    .fb(fb)
  );
  // ====================
  // Clock and run limit
  // Clock at 250 MHz.
  initial begin
    forever #2 clk = ~clk;
  end
  // A hang is cut short well beyond the longest expected run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
  // ====================
  // Helpers
  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Sampling 1 ns past the edge lets registered outputs settle first.
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : at
  // Pairs 1 to 5 are one-hot, pairs 6 to 10 have a single low input.
  function automatic logic [4:0] code(input int k);
    return (k < 5) ? 5'h01 << k : ~(5'h01 << (9 - k));
  endfunction : code
  task automatic sel(input int a, input int b);
    @(posedge clk);
    grp_a <= code(a);
    grp_b <= code(b);
    at(12);
  endtask : sel
  task automatic put_field(input logic [1:0] v, input int n);
    @(posedge clk);
    field <= v;
    at(n);
  endtask : put_field
  task automatic put_link(input logic [1:0] v, input int n);
    @(posedge clk);
    link_ch <= v;
    at(n);
  endtask : put_link
  // ====================
  // Scenarios
  task automatic t_select();
    // The first pattern after reset shows the changeover while nothing is on yet.
    @(posedge clk);
    grp_a <= code(4);
    at(3);
    chk({3'h0, ind[1]}, 4'h1);
    chk({2'h0, out_a}, 4'h0);
    for (int k = 0; k < 10; k++) begin
      sel(k, 9 - k);
      chk(pair_a, 4'(k));
      chk(pair_b, 4'(9 - k));
      chk({out_b, out_a}, 4'hF);
    end
  endtask : t_select
  task automatic t_contour();
    @(posedge clk);
    dev <= 16'h00C9;
    at(6);
    chk({out_b, out_a}, 4'h0);
    @(posedge clk);
    dev <= 16'h00C8;
    at(12);
    chk({out_b, out_a}, 4'hF);
  endtask : t_contour
  task automatic t_standby();
    @(posedge clk);
    stby <= 10'h200;
    at(6);
    chk({2'h0, mon_act}, 4'h2);
    chk({out_b, out_a}, 4'hC);
    @(posedge clk);
    stby <= 10'h000;
    at(12);
    chk({out_b, out_a}, 4'hF);
  endtask : t_standby
  // Both linkage kinds share one check: late off, simultaneity and recovery.
  task automatic t_link();
    for (int m = 1; m < 3; m++) begin
      @(posedge clk);
      link_mode <= 2'(m);
      put_link(2'h2, 3);
      chk({2'h0, out_a}, 4'h3);
      at(7);
      chk({2'h0, out_a}, 4'h0);
      put_link(2'h0, 3);
      put_link(2'h1, 30);
      chk({3'h0, lfault}, 4'h1);
      chk({2'h0, out_a}, 4'h0);
      put_link(2'h0, 3);
      chk({3'h0, lfault}, 4'h0);
      put_link(2'h3, 14);
      chk({2'h0, out_a}, 4'h3);
    end
    @(posedge clk);
    link_mode <= 2'h0;
  endtask : t_link
  task automatic t_delay();
    @(posedge clk);
    two_fn <= 1'b0;
    delay_en <= 1'b1;
    put_field(2'h2, 6);
    chk({out_b, out_a}, 4'hC);
    chk({3'h0, ind[0]}, 4'h1);
    chk({3'h0, ind[3]}, 4'h1);
    at(16);
    chk({out_b, out_a}, 4'h0);
    put_field(2'h3, 12);
    put_field(2'h2, 0);
    put_field(2'h3, 6);
    chk({2'h0, out_a}, 4'h0);
    at(20);
    chk({out_b, out_a}, 4'hF);
    @(posedge clk);
    two_fn <= 1'b1;
    delay_en <= 1'b0;
    at(12);
  endtask : t_delay
  // A welded contact never opens, so the feedback check must latch the interlock.
  task automatic t_feedback();
    put_field(2'h2, 8);
    @(posedge clk);
    brk <= 2'h1;
    put_field(2'h3, 10);
    chk({2'h0, out_a}, 4'h0);
    @(posedge clk);
    fb_chk_en <= 1'b0;
    at(6);
    chk({2'h0, out_a}, 4'h3);
    @(posedge clk);
    fb_chk_en <= 1'b1;
    brk <= 2'h0;
    put_field(2'h2, 8);
    @(posedge clk);
    weld <= 2'h1;
    put_field(2'h3, 30);
    chk({3'h0, intl}, 4'h1);
    chk({out_b, out_a}, 4'h0);
    chk({3'h0, ind[2]}, 4'h1);
    @(posedge clk);
    weld <= 2'h0;
    at(8);
    chk({3'h0, intl}, 4'h1);
    @(posedge clk);
    fault_rst <= 1'b1;
    @(posedge clk);
    fault_rst <= 1'b0;
    at(16);
    chk({3'h0, intl}, 4'h0);
    chk({out_b, out_a}, 4'hF);
  endtask : t_feedback
  task automatic t_order();
    @(posedge clk);
    order_en <= 1'b1;
    deact <= 10'h008;
    allow_a[92] <= 1'b0;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    at(8);
    chk({out_b, out_a}, 4'hF);
    sel(2, 3);
    chk({out_b, out_a}, 4'h0);
  endtask : t_order
  // ====================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    t_select();
    t_contour();
    t_standby();
    t_link();
    t_delay();
    t_feedback();
    t_order();
    summarize();
  end
endmodule : tb_safety_output_supervisor
